// ===== include/ext_irq_defs.svh
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// Register index; each register is one aligned word, so the bus uses four times it.
`define EXT_IRQ_STATUS_CONTROL_INDEX 12'h01F
// Register byte address on the APB bus.
`define EXT_IRQ_STATUS_CONTROL_ADDR 12'h07C
// Field positions within the status and control register.
`define PIN_INT_ENABLE_BIT 7
`define PORT_INT_ENABLE_BIT 6
`define PIN_INT_FLAG_BIT 5
`define PORT_INT_FLAG_BIT 4
`define EXT_INT_ACK_BIT 3
// Reset values.
`define PIN_INT_ENABLE_RST 1'b1
`define PORT_INT_ENABLE_RST 1'b0
// Vector addresses.
`define VEC_RESET 16'h3FFE
`define VEC_SOFTWARE_TRAP 16'h3FFC
`define VEC_EXTERNAL 16'h3FFA
`define VEC_TIMER16 16'h3FF8
`define VEC_DATA_LINK 16'h3FF6
`define VEC_SERIAL 16'h3FF4
`define VEC_TIMER8 16'h3FF2
`define VEC_GAUGE 16'h3FF0

`endif

// ===== include/ext_irq_pkg.sv
package ext_irq_pkg;
    typedef enum logic [2:0]
    {
        SRC_NONE = 3'b000,
        SRC_EXT = 3'b001,
        SRC_TIMER16 = 3'b010,
        SRC_DATA_LINK = 3'b011,
        SRC_SERIAL = 3'b100,
        SRC_TIMER8 = 3'b101,
        SRC_GAUGE = 3'b110,
        SRC_TRAP = 3'b111
    } irq_src_e;
endpackage

// ===== hw/external_interrupt_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defs.svh"

// Function
// RULE1: Software trap is taken regardless of the global mask, vector 3FFC.
// RULE2: Pending hardware interrupts are serviced before a software trap when unmasked.
// RULE3: Global mask set blocks all hardware interrupts; clearing it allows them.
// RULE4: Port sources have own latch; merged with pin latch into one request.
// RULE5: Port sources sense falling edges of the AND of enabled port pins.
// RULE6: A port pin interrupts only with direction bit and data bit both zero.
// RULE7: Edge-only mode: pin flag set only by falling edge on the pin.
// RULE8: Level mode: a low pin level also sets the pin flag.
// RULE9: Pin enable gates pin flag, port enable gates port flag, one vector.
// RULE10: External request vectors through 3FFA; latched then synchronised; the code synchronises the pin in two stages before the flag latches it.
// RULE11: Vector fetch clears pin flag but not port flag.
// RULE12: Writing one to acknowledge clears both flags; zero does nothing.
// RULE13: Flags are read-only; acknowledge reads as zero.
// RULE14: Unused register bits read as zero.
// RULE15: Reset clears both flags, sets pin enable, clears port enable.
// RULE16: Stop or wait forces pin enable to one; port enable unchanged.
// RULE17: Pin flag sets only with pin enable; port flag sets regardless.
// RULE18: Flag with enable keeps requesting until flag or enable clears.
// RULE19: Branch-on-pin tests only the raw pin level.
// RULE20: Stop or wait clears the global mask; port edges still recognised.
// RULE21: Sixteen-bit timer flags share 3FF8; serial flags share 3FF4.
// RULE22: Eight-bit timer overflow and periodic requests share 3FF2.
// RULE23: Highest vector address is serviced first among pending sources; the code ranks the trap (3FFC) below every hardware source.
// RULE24: Global mask is set on interrupt entry before the vector fetch.
// RULE25: Pin and port inputs pass a two-stage synchroniser before edge detection.
module external_interrupt_ctrl
    import ext_irq_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic intPin_n,
    input wire logic [7:0] portPin,
    input wire logic [7:0] portDir,
    input wire logic [7:0] portData,
    input wire logic levelSense,
    input wire logic maskSet,
    input wire logic maskClear,
    input wire logic lowPowerEntry,
    input wire logic trapFetched,
    input wire logic serviceStart,
    input wire logic [2:0] timer16Req,
    input wire logic dataLinkReq,
    input wire logic [1:0] serialReq,
    input wire logic overflowFlag,
    input wire logic overflowIntEnable,
    input wire logic periodicFlag,
    input wire logic periodicIntEnable,
    input wire logic gaugeReq,
    output logic globalMask,
    output logic extIrqReq,
    output logic irqPending,
    output logic [15:0] vectorAddr,
    output logic pinLevel
);

    logic [1:0] pinSync;
    logic [7:0] portSync0;
    logic [7:0] portSync1;
    logic pinPrev;
    logic portAndPrev;
    logic pinIntEnable;
    logic portIntEnable;
    logic pinIntFlag;
    logic portIntFlag;
    logic trapPending;
    logic regWrite;
    logic regRead;
    logic addrHit;
    logic ackWrite;
    logic pinSet;
    logic portSet;
    logic portAnd;
    logic extActive;
    irq_src_e next_src;

    function automatic logic [15:0] src_vector(input irq_src_e s);
        unique case (s)
            SRC_NONE: src_vector = `VEC_RESET;
            SRC_EXT: src_vector = `VEC_EXTERNAL; // RULE10
            SRC_TIMER16: src_vector = `VEC_TIMER16; // RULE21
            SRC_DATA_LINK: src_vector = `VEC_DATA_LINK;
            SRC_SERIAL: src_vector = `VEC_SERIAL; // RULE21
            SRC_TIMER8: src_vector = `VEC_TIMER8; // RULE22
            SRC_GAUGE: src_vector = `VEC_GAUGE;
            SRC_TRAP: src_vector = `VEC_SOFTWARE_TRAP; // RULE1
        endcase
    endfunction

    assign addrHit = (paddr == `EXT_IRQ_STATUS_CONTROL_ADDR);
    assign regWrite = psel && penable && pwrite && addrHit;
    assign regRead = psel && !pwrite && addrHit;
    assign ackWrite = regWrite && pwdata[`EXT_INT_ACK_BIT]; // RULE12

    // Only pins with direction and data both zero join the AND; others read as high.
    assign portAnd = &(portSync1 | portDir | portData); // RULE5 RULE6

    // Pin enable is required for the pin flag to set at all.
    assign pinSet = pinIntEnable && ((pinPrev && !pinSync[1])
        || (levelSense && !pinSync[1])); // RULE7 RULE8 RULE17
    assign portSet = portAndPrev && !portAnd; // RULE5 RULE17 RULE20

    assign extActive = (pinIntFlag && pinIntEnable)
        || (portIntFlag && portIntEnable); // RULE4 RULE9 RULE18

    // Hardware sources outrank the trap so pending ones are taken first.
    always_comb
    begin
        next_src = SRC_NONE;
        if (!globalMask && extActive) // RULE3 RULE23
            next_src = SRC_EXT;
        else if (!globalMask && (|timer16Req))
            next_src = SRC_TIMER16;
        else if (!globalMask && dataLinkReq)
            next_src = SRC_DATA_LINK;
        else if (!globalMask && (|serialReq))
            next_src = SRC_SERIAL;
        else if (!globalMask && ((overflowFlag && overflowIntEnable)
            || (periodicFlag && periodicIntEnable))) // RULE22
            next_src = SRC_TIMER8;
        else if (!globalMask && gaugeReq)
            next_src = SRC_GAUGE;
        else if (trapPending) // RULE1 RULE2
            next_src = SRC_TRAP;
    end

    // Second stage alone feeds the edge logic, keeping metastability contained.
    // Both stages start at the idle high level, so no false edge follows reset.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinSync <= 2'h3;
        end
        else
        begin
            pinSync <= {pinSync[0], intPin_n}; // RULE25
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            portSync0 <= 8'hFF;
            portSync1 <= 8'hFF;
        end
        else
        begin
            portSync0 <= portPin; // RULE25
            portSync1 <= portSync0;
        end
    end

    // The previous level is what turns a synchronised level into an edge.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinPrev <= 1'b1;
        end
        else
        begin
            pinPrev <= pinSync[1];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            portAndPrev <= 1'b1;
        end
        else
        begin
            portAndPrev <= portAnd;
        end
    end

    // Low-power entry outranks software so the pin can always wake the core.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinIntEnable <= `PIN_INT_ENABLE_RST; // RULE15
        end
        else
        begin
            if (lowPowerEntry)
                pinIntEnable <= 1'b1; // RULE16
            else if (regWrite)
                pinIntEnable <= pwdata[`PIN_INT_ENABLE_BIT];
        end
    end

    // Low-power entry leaves this enable alone, so software must set it first.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            portIntEnable <= `PORT_INT_ENABLE_RST; // RULE15
        end
        else
        begin
            if (regWrite)
                portIntEnable <= pwdata[`PORT_INT_ENABLE_BIT]; // RULE16
        end
    end

    // A set in the same cycle as an acknowledge or vector fetch wins.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinIntFlag <= 1'b0; // RULE15
        end
        else
        begin
            if (pinSet)
                pinIntFlag <= 1'b1; // RULE10
            else if (ackWrite || (serviceStart && next_src == SRC_EXT))
                pinIntFlag <= 1'b0; // RULE11 RULE12 RULE13
        end
    end

    // The vector fetch leaves this flag, so software can still tell the source.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            portIntFlag <= 1'b0;
        end
        else
        begin
            if (portSet)
                portIntFlag <= 1'b1; // RULE4
            else if (ackWrite)
                portIntFlag <= 1'b0; // RULE11 RULE12
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            globalMask <= 1'b1;
        end
        else
        begin
            if (serviceStart && next_src != SRC_NONE)
                globalMask <= 1'b1; // RULE24
            else if (lowPowerEntry || maskClear)
                globalMask <= 1'b0; // RULE20 RULE3
            else if (maskSet)
                globalMask <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trapPending <= 1'b0;
        end
        else
        begin
            if (trapFetched)
                trapPending <= 1'b1;
            else if (serviceStart && next_src == SRC_TRAP)
                trapPending <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            extIrqReq <= 1'b0;
        end
        else
        begin
            extIrqReq <= extActive && !globalMask; // RULE18 RULE3
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irqPending <= 1'b0;
        end
        else
        begin
            irqPending <= (next_src != SRC_NONE);
        end
    end

    // The vector lags the selection by one cycle; the core fetches it later anyway.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vectorAddr <= `VEC_RESET;
        end
        else
        begin
            vectorAddr <= src_vector(next_src); // RULE23
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinLevel <= 1'b1;
        end
        else
        begin
            pinLevel <= pinSync[1]; // RULE19
        end
    end

    // The slave answers without wait states and never flags an error.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= 1'b0;
        end
    end

    // Read data is captured in the setup cycle so it stands through the access cycle.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prdata <= 32'h0000_0000;
        end
        else
        begin
            prdata <= 32'h0000_0000; // RULE14
            if (regRead && !penable)
            begin
                prdata[`PIN_INT_ENABLE_BIT] <= pinIntEnable;
                prdata[`PORT_INT_ENABLE_BIT] <= portIntEnable;
                prdata[`PIN_INT_FLAG_BIT] <= pinIntFlag;
                prdata[`PORT_INT_FLAG_BIT] <= portIntFlag; // RULE13
            end
        end
    end

endmodule
`default_nettype wire

// ===== tb/external_interrupt_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module external_interrupt_ctrl_assertions (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic globalMask,
    input wire logic extIrqReq,
    input wire logic maskSet,
    input wire logic maskClear,
    input wire logic serviceStart,
    input wire logic lowPowerEntry,
    input wire logic intPin_n,
    input wire logic pinLevel,
    input wire logic trapFetched,
    input wire logic irqPending
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_no_error: assert property (!pslverr)
        else $error("error response seen");
    a_mask_blocks: assert property (globalMask [*2] |-> !extIrqReq)
        else $error("request while masked");
    a_lp_unmask: assert property (lowPowerEntry && !maskSet && !serviceStart |=> !globalMask)
        else $error("mask kept in low power");
    a_entry_mask: assert property (serviceStart && !lowPowerEntry && !maskClear |=> globalMask)
        else $error("mask not set on entry");
    a_pin_high: assert property (intPin_n [*4] |-> pinLevel)
        else $error("pin level not high");
    a_pin_low: assert property (!intPin_n [*4] |-> !pinLevel)
        else $error("pin level not low");
    a_trap_pend: assert property (trapFetched |-> ##[1:3] irqPending)
        else $error("trap not pending");
endmodule
`default_nettype wire

// ===== tb/ext_irq_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ext_irq_cpu_model #(
    parameter int LATENCY = 3
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic irqPending,
    output logic serviceStart
);
    int count;
    logic taken;
    // The core ends its instruction first, so the vector fetch lags the request.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= 0;
            taken <= 1'b0;
            serviceStart <= 1'b0;
        end
        else
        begin
            serviceStart <= go && irqPending && !taken && count == LATENCY;
            count <= (go && irqPending && !taken) ? count + 1 : 0;
            taken <= go && (taken || serviceStart);
        end
    end
endmodule
`default_nettype wire

// ===== tb/external_interrupt_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ext_irq_defs.svh"
module external_interrupt_ctrl_tb_top;
    logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, intPin_n = 1, levelSense = 0;
    logic maskSet = 0, maskClear = 0, lowPowerEntry = 0, trapFetched = 0, go = 0, gaugeReq = 0;
    logic dataLinkReq = 0, overflowFlag = 0, overflowIntEnable = 0, periodicFlag = 0;
    logic periodicIntEnable = 0, pready, pslverr, globalMask, extIrqReq, irqPending, pinLevel;
    logic serviceStart, pinEn, portEn, pinFl, portFl;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, r, seed = 32'h0000_7b4c;
    logic [15:0] vectorAddr;
    logic [7:0] portPin = 8'hff, portDir = 0, portData = 0;
    logic [2:0] timer16Req = 0;
    logic [1:0] serialReq = 0;
    int mismatches = 0, total_checks = 0;
    external_interrupt_ctrl u_dut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .intPin_n, .portPin, .portDir, .portData, .levelSense, .maskSet, .maskClear,
        .lowPowerEntry, .trapFetched, .serviceStart, .timer16Req, .dataLinkReq, .serialReq,
        .overflowFlag, .overflowIntEnable, .periodicFlag, .periodicIntEnable, .gaugeReq, .globalMask,
        .extIrqReq, .irqPending, .vectorAddr, .pinLevel);
    ext_irq_cpu_model #(.LATENCY(3)) u_cpu (.clk, .arst_n, .go, .irqPending, .serviceStart);
    always #20 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] ev();
        return {24'h0, pinEn, portEn, pinFl, portFl, 4'h0};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic fail_out();
        mismatches++;
        results();
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1)
            fail_out();
        @(posedge clk);
    endtask
    task automatic rdchk();
        apb(0, `EXT_IRQ_STATUS_CONTROL_ADDR, 0);
        chk(ev(), rd);
    endtask
    task automatic waitv(input logic [15:0] e);
        int n;
        n = 0;
        do @(posedge clk); while (vectorAddr !== e && ++n < 32);
        chk({16'h0, e}, {16'h0, vectorAddr});
    endtask
    task automatic serve();
        int n;
        n = 0;
        go <= 1;
        do @(posedge clk); while (serviceStart !== 1'b1 && ++n < 32);
        go <= 0;
        if (serviceStart !== 1'b1)
            fail_out();
        repeat (2) @(posedge clk);
    endtask
    initial
    begin
        #800000;
        fail_out();
    end
    initial
    begin
        {pinEn, portEn, pinFl, portFl} = 4'h8;
        repeat (16) @(posedge clk);
        arst_n <= 1;
        @(posedge clk);
        rdchk();
        apb(0, 12'h020, 32'h0000_0000);
        chk(0, rd);
        trapFetched <= 1;
        @(posedge clk);
        trapFetched <= 0;
        waitv(`VEC_SOFTWARE_TRAP);
        serve();
        r = rnd();
        apb(1, `EXT_IRQ_STATUS_CONTROL_ADDR, r & 32'hffff_fff7);
        {pinEn, portEn} = r[7:6];
        rdchk();
        apb(1, `EXT_IRQ_STATUS_CONTROL_ADDR, 32'h0000_0080);
        {pinEn, portEn} = 2'b10;
        intPin_n <= 0;
        repeat (6) @(posedge clk);
        intPin_n <= 1;
        repeat (6) @(posedge clk);
        pinFl = 1;
        rdchk();
        r = rnd();
        portData <= 8'h01 << r[2:0];
        portPin <= ~(8'h01 << r[2:0]);
        repeat (8) @(posedge clk);
        rdchk();
        portData <= 0;
        portPin <= 8'hff;
        repeat (8) @(posedge clk);
        portPin <= ~(8'h01 << r[2:0]);
        repeat (8) @(posedge clk);
        portFl = 1;
        rdchk();
        maskClear <= 1;
        @(posedge clk);
        maskClear <= 0;
        waitv(`VEC_EXTERNAL);
        chk(1, extIrqReq);
        serve();
        pinFl = 0;
        rdchk();
        apb(1, `EXT_IRQ_STATUS_CONTROL_ADDR, 32'h0000_0088);
        portFl = 0;
        rdchk();
        levelSense <= 1;
        intPin_n <= 0;
        repeat (8) @(posedge clk);
        apb(1, `EXT_IRQ_STATUS_CONTROL_ADDR, 32'h0000_0088);
        repeat (8) @(posedge clk);
        pinFl = 1;
        rdchk();
        intPin_n <= 1;
        repeat (4) @(posedge clk);
        apb(1, `EXT_IRQ_STATUS_CONTROL_ADDR, 32'h0000_0048);
        lowPowerEntry <= 1;
        @(posedge clk);
        lowPowerEntry <= 0;
        repeat (2) @(posedge clk);
        {pinEn, portEn, pinFl} = 3'b110;
        rdchk();
        chk(0, globalMask);
        {overflowFlag, overflowIntEnable, periodicFlag, periodicIntEnable} <= 4'hf;
        waitv(`VEC_TIMER8);
        timer16Req <= 3'b100;
        waitv(`VEC_TIMER16);
        results();
    end
endmodule
bind external_interrupt_ctrl external_interrupt_ctrl_assertions u_chk (.clk, .arst_n, .psel,
    .penable, .pready, .pslverr, .globalMask, .extIrqReq, .maskSet, .maskClear, .serviceStart,
    .lowPowerEntry, .intPin_n, .pinLevel, .trapFetched, .irqPending);
`default_nettype wire
